// ===== inc/ivf_pkg.sv
// Package of constants and types for the input voltage fault supervisor
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
package ivf_pkg;

    // -------------------------------------------------------------------------
    // Register offsets
    // -------------------------------------------------------------------------
    localparam logic [7:0] IVF_OFS_LOW_LIMIT = 8'h00;
    localparam logic [7:0] IVF_OFS_LOW_ACTION = 8'h04;
    localparam logic [7:0] IVF_OFS_HIGH_LIMIT = 8'h08;
    localparam logic [7:0] IVF_OFS_HIGH_ACTION = 8'h0c;
    localparam logic [7:0] IVF_OFS_DELAY = 8'h10;
    localparam logic [7:0] IVF_OFS_CONTROL = 8'h14;
    localparam logic [7:0] IVF_OFS_STATUS = 8'h18;
    localparam logic [7:0] IVF_OFS_CLEAR = 8'h1c;
    localparam logic [7:0] IVF_OFS_ENABLE = 8'h20;
    localparam logic [7:0] IVF_OFS_RATIO = 8'h24;
    localparam logic [7:0] IVF_OFS_LIVE = 8'h28;

    // -------------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------------
    localparam int IVF_BIT_UV = 0;
    localparam int IVF_BIT_OV = 1;
    localparam int IVF_BIT_CTL_ENABLE = 0;
    localparam int IVF_BIT_CTL_CLEAR = 1;
    localparam int IVF_BIT_LIVE_OUT = 0;
    localparam int IVF_BIT_LIVE_UV = 1;
    localparam int IVF_BIT_LIVE_OV = 2;
    localparam int IVF_BIT_LIVE_LATCH = 3;
    localparam int IVF_BIT_LIVE_LOCK = 4;

    // -------------------------------------------------------------------------
    // Reset values and limits
    // -------------------------------------------------------------------------
    localparam logic [15:0] IVF_RST_LOW_LIMIT = 16'h0000;
    localparam logic [15:0] IVF_RST_HIGH_LIMIT = 16'hffff;
    localparam logic [1:0] IVF_RST_ACTION = 2'h3;
    localparam logic [31:0] IVF_RST_DELAY = 32'h0000_0010;
    localparam logic [7:0] IVF_RATIO_MIN = 8'h19;
    localparam logic [7:0] IVF_RATIO_MAX = 8'h42;

    // -------------------------------------------------------------------------
    // Types
    // -------------------------------------------------------------------------
    typedef enum logic [1:0] {
        IVF_ACT_IGNORE,
        IVF_ACT_DELAYED,
        IVF_ACT_LATCHED,
        IVF_ACT_RETRY
    } ivf_action_type;

    typedef enum logic [1:0] {
        IVF_ST_RUN,
        IVF_ST_WAIT,
        IVF_ST_LATCHED,
        IVF_ST_RETRY
    } ivf_state_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ivf_bus_req_type;

    typedef struct packed {
        logic [15:0] value;
        logic valid;
    } ivf_sample_type;

endpackage

// ===== src/ivf_guard.sv
// One threshold guard: compare, action state machine and shutdown request
`timescale 1ns/1ps
module ivf_guard (
    input wire logic clk,
    input wire logic rst,
    input wire logic is_high,
    input wire ivf_pkg::ivf_sample_type sample,
    input wire logic [15:0] limit,
    input wire ivf_pkg::ivf_action_type action,
    input wire logic [31:0] delay,
    input wire logic clear,
    input wire logic enable_rise,
    output logic fault,
    output logic shut,
    output logic latched
);
    typedef struct packed {
        ivf_pkg::ivf_state_type st;
        logic fault;
        logic [31:0] cnt;
    } ivf_guard_state_type;

    ivf_guard_state_type s_q, s_d;
    logic beyond;

    // -------------------------------------------------------------------------
    // Compare and act
    // -------------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        beyond = is_high ? (sample.value > limit) : (sample.value < limit);
        if (sample.valid) begin
            s_d.fault = beyond;
        end
        unique case (s_q.st)
            ivf_pkg::IVF_ST_RUN: begin
                if (s_d.fault) begin
                    unique case (action)
                        ivf_pkg::IVF_ACT_IGNORE: s_d.st = ivf_pkg::IVF_ST_RUN;
                        ivf_pkg::IVF_ACT_DELAYED: begin
                            s_d.st = ivf_pkg::IVF_ST_WAIT;
                            s_d.cnt = delay;
                        end
                        ivf_pkg::IVF_ACT_LATCHED: s_d.st = ivf_pkg::IVF_ST_LATCHED;
                        ivf_pkg::IVF_ACT_RETRY: s_d.st = ivf_pkg::IVF_ST_RETRY;
                    endcase
                end
            end
            ivf_pkg::IVF_ST_WAIT: begin
                if (s_q.cnt == 32'h0000_0000) begin
                    s_d.st = s_d.fault ? ivf_pkg::IVF_ST_LATCHED : ivf_pkg::IVF_ST_RUN;
                end else begin
                    s_d.cnt = s_q.cnt - 32'h0000_0001;
                end
            end
            ivf_pkg::IVF_ST_LATCHED: begin
                if (clear || enable_rise) begin
                    s_d.st = ivf_pkg::IVF_ST_RUN;
                end
            end
            ivf_pkg::IVF_ST_RETRY: begin
                if (!s_d.fault) begin
                    s_d.st = ivf_pkg::IVF_ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign fault = s_q.fault;
    assign shut = (s_q.st == ivf_pkg::IVF_ST_LATCHED) || (s_q.st == ivf_pkg::IVF_ST_RETRY);
    assign latched = (s_q.st == ivf_pkg::IVF_ST_LATCHED);

endmodule // ivf_guard

// ===== src/ivf_top.sv
// Input voltage fault supervisor top with register port and resonance clamp
`timescale 1ns/1ps
module ivf_top (
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic [15:0] VIN_SAMPLE,
    input wire logic VIN_VALID,
    input wire logic [15:0] RATIO_IN,
    input wire logic RATIO_VALID,
    input wire logic LOCKOUT,
    input wire logic REMOTE_ON,
    output logic OUTPUT_ENABLE,
    output logic FAULT_ALERT_PIN,
    output logic IRQ
);
    typedef struct packed {
        logic [15:0] low_limit;
        ivf_pkg::ivf_action_type low_action;
        logic [15:0] high_limit;
        ivf_pkg::ivf_action_type high_action;
        logic [31:0] delay;
        logic sw_enable;
        logic [1:0] status;
        logic [1:0] irq_en;
        logic [15:0] ratio;
        logic run_q;
        logic [31:0] rdata;
        logic out_en;
        logic alert;
        logic irq;
    } ivf_top_state_type;

    ivf_top_state_type s_q, s_d;
    ivf_pkg::ivf_bus_req_type req;
    ivf_pkg::ivf_sample_type smp;
    logic uv_fault, ov_fault, uv_shut, ov_shut, uv_latch, ov_latch;
    logic clear, run_req, enable_rise, wr_ok;

    // Clamp the integer part of an 8.8 ratio to the allowed window
    function automatic logic [15:0] clamp_ratio(input logic [15:0] r);
        if (r[15:8] < ivf_pkg::IVF_RATIO_MIN) begin
            return {ivf_pkg::IVF_RATIO_MIN, 8'h00};
        end else if (r[15:8] >= ivf_pkg::IVF_RATIO_MAX) begin
            return {ivf_pkg::IVF_RATIO_MAX, 8'h00};
        end else begin
            return r;
        end
    endfunction

    // -------------------------------------------------------------------------
    // Bus and command decode
    // -------------------------------------------------------------------------
    assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
    assign smp = '{value: VIN_SAMPLE, valid: VIN_VALID};
    assign wr_ok = req.wr && !LOCKOUT;
    assign clear = wr_ok && (req.addr == ivf_pkg::IVF_OFS_CONTROL) &&
        req.wdata[ivf_pkg::IVF_BIT_CTL_CLEAR];
    assign run_req = s_q.sw_enable && REMOTE_ON && !LOCKOUT;
    assign enable_rise = run_req && !s_q.run_q;

    ivf_guard u_low (
        .clk(SYS_CLK),
        .rst(SRST),
        .is_high(1'b0),
        .sample(smp),
        .limit(s_q.low_limit),
        .action(s_q.low_action),
        .delay(s_q.delay),
        .clear(clear),
        .enable_rise(enable_rise),
        .fault(uv_fault),
        .shut(uv_shut),
        .latched(uv_latch)
    );

    ivf_guard u_high (
        .clk(SYS_CLK),
        .rst(SRST),
        .is_high(1'b1),
        .sample(smp),
        .limit(s_q.high_limit),
        .action(s_q.high_action),
        .delay(s_q.delay),
        .clear(clear),
        .enable_rise(enable_rise),
        .fault(ov_fault),
        .shut(ov_shut),
        .latched(ov_latch)
    );

    // -------------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.run_q = run_req;
        if (wr_ok) begin
            unique case (req.addr)
                ivf_pkg::IVF_OFS_LOW_LIMIT: s_d.low_limit = req.wdata[15:0];
                ivf_pkg::IVF_OFS_LOW_ACTION:
                    s_d.low_action = ivf_pkg::ivf_action_type'(req.wdata[1:0]);
                ivf_pkg::IVF_OFS_HIGH_LIMIT: s_d.high_limit = req.wdata[15:0];
                ivf_pkg::IVF_OFS_HIGH_ACTION:
                    s_d.high_action = ivf_pkg::ivf_action_type'(req.wdata[1:0]);
                ivf_pkg::IVF_OFS_DELAY: s_d.delay = req.wdata;
                ivf_pkg::IVF_OFS_CONTROL: s_d.sw_enable = req.wdata[ivf_pkg::IVF_BIT_CTL_ENABLE];
                ivf_pkg::IVF_OFS_CLEAR: s_d.status = s_q.status & ~req.wdata[1:0];
                ivf_pkg::IVF_OFS_ENABLE: s_d.irq_en = req.wdata[1:0];
                default: s_d.status = s_q.status;
            endcase
        end
        if (clear) begin
            s_d.status = 2'b00;
        end
        if (uv_fault) begin
            s_d.status[ivf_pkg::IVF_BIT_UV] = 1'b1;
        end
        if (ov_fault) begin
            s_d.status[ivf_pkg::IVF_BIT_OV] = 1'b1;
        end
        if (RATIO_VALID) begin
            s_d.ratio = clamp_ratio(RATIO_IN);
        end
        s_d.out_en = run_req && !uv_shut && !ov_shut;
        s_d.alert = |s_d.status;
        s_d.irq = |(s_d.status & s_d.irq_en);
        s_d.rdata = 32'h0000_0000;
        if (req.rd) begin
            unique case (req.addr)
                ivf_pkg::IVF_OFS_LOW_LIMIT: s_d.rdata = {16'h0000, s_q.low_limit};
                ivf_pkg::IVF_OFS_LOW_ACTION: s_d.rdata = {30'h0, s_q.low_action};
                ivf_pkg::IVF_OFS_HIGH_LIMIT: s_d.rdata = {16'h0000, s_q.high_limit};
                ivf_pkg::IVF_OFS_HIGH_ACTION: s_d.rdata = {30'h0, s_q.high_action};
                ivf_pkg::IVF_OFS_DELAY: s_d.rdata = s_q.delay;
                ivf_pkg::IVF_OFS_CONTROL: s_d.rdata = {31'h0, s_q.sw_enable};
                ivf_pkg::IVF_OFS_STATUS: s_d.rdata = {30'h0, s_q.status};
                ivf_pkg::IVF_OFS_ENABLE: s_d.rdata = {30'h0, s_q.irq_en};
                ivf_pkg::IVF_OFS_RATIO: s_d.rdata = {16'h0000, s_q.ratio};
                ivf_pkg::IVF_OFS_LIVE: s_d.rdata = {27'h0, LOCKOUT, uv_latch | ov_latch,
                    ov_fault, uv_fault, s_q.out_en};
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // State register
    // -------------------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            s_q <= '0;
            s_q.low_limit <= ivf_pkg::IVF_RST_LOW_LIMIT;
            s_q.high_limit <= ivf_pkg::IVF_RST_HIGH_LIMIT;
            s_q.low_action <= ivf_pkg::ivf_action_type'(ivf_pkg::IVF_RST_ACTION);
            s_q.high_action <= ivf_pkg::ivf_action_type'(ivf_pkg::IVF_RST_ACTION);
            s_q.delay <= ivf_pkg::IVF_RST_DELAY;
            s_q.ratio <= {ivf_pkg::IVF_RATIO_MIN, 8'h00};
        end else begin
            s_q <= s_d;
        end
    end

    assign RDATA = s_q.rdata;
    assign OUTPUT_ENABLE = s_q.out_en;
    assign FAULT_ALERT_PIN = s_q.alert;
    assign IRQ = s_q.irq;

endmodule // ivf_top

// ===== tb/ivf_checker.sv
// Port checker for the input voltage fault supervisor
`timescale 1ns/1ps
module ivf_checker (
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire logic [15:0] VIN_SAMPLE,
    input wire logic VIN_VALID,
    input wire logic LOCKOUT,
    input wire logic REMOTE_ON,
    input wire logic OUTPUT_ENABLE,
    input wire logic FAULT_ALERT_PIN,
    input wire logic IRQ
);
    logic [15:0] low_q;
    logic [15:0] high_q;
    logic shut_q;
    // -------------------------------------------------------------------------
    // Shadow of limits and low action
    // -------------------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            low_q <= ivf_pkg::IVF_RST_LOW_LIMIT;
            high_q <= ivf_pkg::IVF_RST_HIGH_LIMIT;
            shut_q <= 1'b1;
        end else if (WR && !LOCKOUT) begin
            case (ADDR)
                ivf_pkg::IVF_OFS_LOW_LIMIT: low_q <= WDATA[15:0];
                ivf_pkg::IVF_OFS_HIGH_LIMIT: high_q <= WDATA[15:0];
                ivf_pkg::IVF_OFS_LOW_ACTION: shut_q <= WDATA[1];
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SRST);
    AST_UV_ALERT: assert property (VIN_VALID && VIN_SAMPLE < low_q |-> ##2 FAULT_ALERT_PIN)
        else $error("no alert after low sample");
    AST_OV_ALERT: assert property (VIN_VALID && VIN_SAMPLE > high_q |-> ##2 FAULT_ALERT_PIN)
        else $error("no alert after high sample");
    AST_UV_SHUT: assert property (VIN_VALID && VIN_SAMPLE < low_q && shut_q |->
        ##2 !OUTPUT_ENABLE)
        else $error("output kept after low sample");
    AST_IRQ_ALERT: assert property (IRQ |-> FAULT_ALERT_PIN)
        else $error("irq without alert");
    AST_LOCK_OFF: assert property (LOCKOUT |=> !OUTPUT_ENABLE)
        else $error("output during lockout");
    AST_OE_RISE: assert property ($rose(OUTPUT_ENABLE) |->
        $past(REMOTE_ON) && !$past(LOCKOUT))
        else $error("output rose without enable");
    AST_RST_QUIET: assert property ($fell(SRST) |->
        !OUTPUT_ENABLE && !IRQ && !FAULT_ALERT_PIN)
        else $error("outputs active after reset");
    AST_RD_IDLE: assert property (!$past(RD) |-> RDATA == 32'h0)
        else $error("read data outside its cycle");
    AST_RATIO: assert property (RD && ADDR == ivf_pkg::IVF_OFS_RATIO |=>
        RDATA[15:8] >= ivf_pkg::IVF_RATIO_MIN && RDATA[15:8] <= ivf_pkg::IVF_RATIO_MAX
        && (RDATA[15:8] != ivf_pkg::IVF_RATIO_MAX || RDATA[7:0] == 8'h00))
        else $error("ratio outside clamp");
    COV_SHUT: cover property ($fell(OUTPUT_ENABLE));
    COV_IRQ: cover property ($rose(IRQ));
    COV_LOCK: cover property (LOCKOUT && WR);
endmodule // ivf_checker

bind ivf_top ivf_checker chk_u (.SYS_CLK(SYS_CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .VIN_SAMPLE(VIN_SAMPLE), .VIN_VALID(VIN_VALID),
    .LOCKOUT(LOCKOUT), .REMOTE_ON(REMOTE_ON), .OUTPUT_ENABLE(OUTPUT_ENABLE),
    .FAULT_ALERT_PIN(FAULT_ALERT_PIN), .IRQ(IRQ));

// ===== tb/ivf_sense_model.sv
// Model of the input voltage and resonance measurement path
`timescale 1ns/1ps
module ivf_sense_model (
    input wire logic clk,
    output logic [15:0] vin_sample,
    output logic vin_valid,
    output logic [15:0] ratio_in,
    output logic ratio_valid
);
    initial begin
        vin_sample = 16'h4000;
        vin_valid = 1'b0;
        ratio_in = 16'h2000;
        ratio_valid = 1'b0;
    end
    task automatic send_vin(input logic [15:0] v);
        @(posedge clk);
        vin_sample <= v;
        vin_valid <= 1'b1;
        @(posedge clk);
        vin_valid <= 1'b0;
        vin_sample <= ~v;
    endtask
    task automatic send_ratio(input logic [15:0] v);
        @(posedge clk);
        ratio_in <= v;
        ratio_valid <= 1'b1;
        @(posedge clk);
        ratio_valid <= 1'b0;
        ratio_in <= ~v;
    endtask
endmodule // ivf_sense_model

// ===== tb/tb.sv
// Self-checking bench for the input voltage fault supervisor
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic hi;
        logic [1:0] act;
        logic [15:0] vin;
        logic oe;
        logic [1:0] st;
    } ivf_row_type;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic lockout = 1'b0;
    logic remote_on = 1'b1;
    logic [31:0] rdata;
    logic oe;
    logic alert;
    logic irq;
    logic [15:0] vin_sample;
    logic vin_valid;
    logic [15:0] ratio_in;
    logic ratio_valid;
    int error_cnt = 0;
    int check_count = 0;
    int i;
    ivf_row_type rows [7] = '{'{1'b0, 2'h0, 16'h0fff, 1'b1, 2'h1},
        '{1'b0, 2'h3, 16'h0fff, 1'b0, 2'h1},
        '{1'b0, 2'h3, 16'h1000, 1'b1, 2'h0}, '{1'b0, 2'h1, 16'h0000, 1'b1, 2'h1},
        '{1'b1, 2'h2, 16'h8001, 1'b0, 2'h2}, '{1'b1, 2'h3, 16'hffff, 1'b0, 2'h2},
        '{1'b1, 2'h0, 16'h8000, 1'b1, 2'h0}};
    logic [15:0] rin [4] = '{16'h1000, 16'h5000, 16'h2a80, 16'h42ff};
    logic [15:0] rout [4] = '{16'h1900, 16'h4200, 16'h2a80, 16'h4200};
    logic [7:0] radr [6] = '{ivf_pkg::IVF_OFS_LOW_ACTION, ivf_pkg::IVF_OFS_HIGH_ACTION,
        ivf_pkg::IVF_OFS_HIGH_LIMIT, ivf_pkg::IVF_OFS_DELAY, ivf_pkg::IVF_OFS_RATIO, 8'h30};
    logic [31:0] rval [6] = '{32'h3, 32'h3, 32'hffff, 32'h10, 32'h1900, 32'h0};
    ivf_top dut_u (.SYS_CLK(sys_clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .VIN_SAMPLE(vin_sample), .VIN_VALID(vin_valid),
        .RATIO_IN(ratio_in), .RATIO_VALID(ratio_valid), .LOCKOUT(lockout),
        .REMOTE_ON(remote_on), .OUTPUT_ENABLE(oe), .FAULT_ALERT_PIN(alert), .IRQ(irq));
    ivf_sense_model src_u (.clk(sys_clk), .vin_sample(vin_sample), .vin_valid(vin_valid),
        .ratio_in(ratio_in), .ratio_valid(ratio_valid));
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    // -------------------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        chk(n, e, rdata);
    endtask
    task automatic settle();
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    task automatic vin(input logic [15:0] v);
        src_u.send_vin(v);
        settle();
    endtask
    task automatic restore();
        vin(16'h4000);
        wreg(ivf_pkg::IVF_OFS_CONTROL, 32'h3);
        wreg(ivf_pkg::IVF_OFS_CLEAR, 32'h3);
        wreg(ivf_pkg::IVF_OFS_LOW_ACTION, 32'h3);
        wreg(ivf_pkg::IVF_OFS_HIGH_ACTION, 32'h3);
        settle();
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        error_cnt++;
        give_verdict();
    end
    // -------------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        wreg(ivf_pkg::IVF_OFS_LOW_LIMIT, 32'h1000);
        wreg(ivf_pkg::IVF_OFS_HIGH_LIMIT, 32'h8000);
        wreg(ivf_pkg::IVF_OFS_ENABLE, 32'h3);
        restore();
        for (i = 0; i < 7; i++) begin
            wreg(rows[i].hi ? ivf_pkg::IVF_OFS_HIGH_ACTION : ivf_pkg::IVF_OFS_LOW_ACTION,
                {30'h0, rows[i].act});
            vin(rows[i].vin);
            chk("row output", 32'(rows[i].oe), 32'(oe));
            rchk("row status", ivf_pkg::IVF_OFS_STATUS, 32'(rows[i].st));
            restore();
        end
        $display("test rows done");
        wreg(ivf_pkg::IVF_OFS_DELAY, 32'h0000_0008);
        wreg(ivf_pkg::IVF_OFS_LOW_ACTION, 32'h1);
        src_u.send_vin(16'h0800);
        for (i = 0; i < 40 && oe === 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        chk("delay length", 32'h0000_000a, 32'(i));
        restore();
        wreg(ivf_pkg::IVF_OFS_LOW_ACTION, 32'h1);
        src_u.send_vin(16'h0800);
        vin(16'h4000);
        repeat (24) @(posedge sys_clk);
        #1;
        chk("delay kept", 32'h1, 32'(oe));
        restore();
        $display("test delayed done");
        wreg(ivf_pkg::IVF_OFS_LOW_ACTION, 32'h2);
        vin(16'h0800);
        vin(16'h4000);
        chk("latch held", 32'h0, 32'(oe));
        wreg(ivf_pkg::IVF_OFS_CONTROL, 32'h3);
        settle();
        chk("latch cleared", 32'h1, 32'(oe));
        vin(16'h0800);
        vin(16'h4000);
        wreg(ivf_pkg::IVF_OFS_CONTROL, 32'h0);
        wreg(ivf_pkg::IVF_OFS_CONTROL, 32'h1);
        settle();
        chk("latch enable", 32'h1, 32'(oe));
        @(posedge sys_clk);
        remote_on <= 1'b0;
        settle();
        chk("remote off", 32'h0, 32'(oe));
        vin(16'h0800);
        vin(16'h4000);
        rchk("latch live", ivf_pkg::IVF_OFS_LIVE, 32'h0000_0008);
        @(posedge sys_clk);
        remote_on <= 1'b1;
        settle();
        chk("latch remote", 32'h1, 32'(oe));
        restore();
        $display("test latched done");
        wreg(ivf_pkg::IVF_OFS_LOW_ACTION, 32'h0);
        vin(16'h0800);
        chk("irq raised", 32'h1, 32'(irq));
        wreg(ivf_pkg::IVF_OFS_ENABLE, 32'h0);
        settle();
        chk("irq masked", 32'h0, 32'(irq));
        chk("alert kept", 32'h1, 32'(alert));
        vin(16'h4000);
        wreg(ivf_pkg::IVF_OFS_CLEAR, 32'h1);
        settle();
        chk("alert cleared", 32'h0, 32'(alert));
        rchk("status cleared", ivf_pkg::IVF_OFS_STATUS, 32'h0);
        restore();
        $display("test interrupt done");
        @(posedge sys_clk);
        lockout <= 1'b1;
        wreg(ivf_pkg::IVF_OFS_LOW_LIMIT, 32'h2000);
        settle();
        chk("lockout output", 32'h0, 32'(oe));
        rchk("lockout live", ivf_pkg::IVF_OFS_LIVE, 32'h10);
        @(posedge sys_clk);
        lockout <= 1'b0;
        rchk("limit kept", ivf_pkg::IVF_OFS_LOW_LIMIT, 32'h1000);
        $display("test lockout done");
        for (i = 0; i < 4; i++) begin
            src_u.send_ratio(rin[i]);
            settle();
            rchk("ratio", ivf_pkg::IVF_OFS_RATIO, {16'h0, rout[i]});
        end
        $display("test ratio done");
        @(posedge sys_clk);
        srst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        for (i = 0; i < 6; i++) begin
            rchk("reset value", radr[i], rval[i]);
        end
        $display("test reset done");
        give_verdict();
    end
endmodule // tb
